// ==== design/rsu_uart.sv ====
// serial port with byte-wide registers and transceiver direction output
`timescale 1ns/1ns
`default_nettype none
module rsu_uart (
    // clock, reset, enable
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire logic I_CE,
    // host register port
    input wire logic [2:0] I_ADDR,
    input wire logic I_RD,
    input wire logic I_WR,
    input wire logic [7:0] I_WDATA,
    output logic [7:0] O_RDATA,
    output logic O_IRQ,
    // line side
    input wire logic I_RXD,
    input wire logic I_CTS,
    output logic O_TXD,
    output logic O_RTS
);
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA = 4'b0100,
        TX_STOP = 4'b1000
    } rsu_tx_t;
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } rsu_rx_t;
    logic [7:0] format_reg;
    logic [7:0] dirctl_reg;
    logic [15:0] divisor_reg;
    logic [7:0] thr_reg;
    logic thr_full_reg;
    logic tick16;
    logic div_sel;
    logic link_run;
    logic [3:0] char_len;
    logic cts_unused;
    rsu_tx_t tx_state_reg;
    logic [3:0] tx_phase_reg;
    logic [2:0] tx_bit_reg;
    logic [7:0] tx_shift_reg;
    logic tx_stop2_reg;
    rsu_rx_t rx_state_reg;
    logic [3:0] rx_phase_reg;
    logic [2:0] rx_bit_reg;
    logic [7:0] rx_shift_reg;
    logic rx_push_reg;
    logic [7:0] rx_char_reg;
    logic host_data_rd;
    logic host_data_wr;
    logic tx_load;
    rsu_stream_if #(.WIDTH(8)) rx_in ();
    rsu_stream_if #(.WIDTH(8)) rx_out ();
    assign div_sel = format_reg[rsu_pkg::FMT_DIV_SEL_BIT];
    assign link_run = !div_sel;
    assign char_len = 4'(rsu_pkg::LEN_BASE) + {2'b00, format_reg[1:0]};
    assign cts_unused = I_CTS;
    assign host_data_rd = I_RD && (I_ADDR == rsu_pkg::OFS_DATA) && !div_sel;
    assign host_data_wr = I_WR && (I_ADDR == rsu_pkg::OFS_DATA) && !div_sel;

    rsu_baud u_baud (
        .i_clk(I_CLOCK),
        .i_rst(I_RST),
        .i_ce(I_CE),
        .i_divisor(divisor_reg),
        .o_tick16(tick16)
    );

    rsu_fifo #(.WIDTH(8), .DEPTH(rsu_pkg::FIFO_DEPTH)) u_rx_fifo (
        .i_clk(I_CLOCK),
        .i_rst(I_RST),
        .i_ce(I_CE),
        .wr(rx_in.snk),
        .rd(rx_out.src)
    );
    assign rx_in.valid = rx_push_reg;
    assign rx_in.data = rx_char_reg;
    assign rx_out.ready = host_data_rd;

    // register writes
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            format_reg <= rsu_pkg::FORMAT_RESET;
            dirctl_reg <= rsu_pkg::DIRCTL_RESET;
            divisor_reg <= rsu_pkg::DIVISOR_RESET;
        end else if (I_CE && I_WR) begin
            if (I_ADDR == rsu_pkg::OFS_DATA && div_sel) begin
                divisor_reg[7:0] <= I_WDATA;
            end else if (I_ADDR == rsu_pkg::OFS_DIV_HI && div_sel) begin
                divisor_reg[15:8] <= I_WDATA;
            end else if (I_ADDR == rsu_pkg::OFS_FORMAT) begin
                format_reg <= I_WDATA;
            end else if (I_ADDR == rsu_pkg::OFS_DIRCTL) begin
                dirctl_reg <= I_WDATA;
            end
        end
    end

    // holding register: set by host write wins over hand-off to shifter
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            thr_reg <= 8'h00;
            thr_full_reg <= 1'b0;
        end else if (I_CE) begin
            if (host_data_wr) begin
                thr_reg <= I_WDATA;
                thr_full_reg <= 1'b1;
            end else if (tx_load) begin
                thr_full_reg <= 1'b0;
            end
        end
    end

    // read mux
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            O_RDATA <= 8'h00;
        end else if (I_CE && I_RD) begin
            if (I_ADDR == rsu_pkg::OFS_DATA) begin
                O_RDATA <= div_sel ? divisor_reg[7:0] : rx_out.data;
            end else if (I_ADDR == rsu_pkg::OFS_DIV_HI) begin
                O_RDATA <= div_sel ? divisor_reg[15:8] : 8'h00;
            end else if (I_ADDR == rsu_pkg::OFS_IRQ_ID) begin
                O_RDATA <= rx_out.valid ? rsu_pkg::IRQ_ID_RX : rsu_pkg::IRQ_ID_NONE;
            end else if (I_ADDR == rsu_pkg::OFS_FORMAT) begin
                O_RDATA <= format_reg;
            end else if (I_ADDR == rsu_pkg::OFS_DIRCTL) begin
                O_RDATA <= dirctl_reg;
            end else if (I_ADDR == rsu_pkg::OFS_FLAGS) begin
                O_RDATA <= 8'h00;
                O_RDATA[rsu_pkg::FLG_READY_BIT] <= rx_out.valid;
                O_RDATA[rsu_pkg::FLG_THR_EMPTY_BIT] <= !thr_full_reg;
            end else begin
                O_RDATA <= 8'h00;
            end
        end
    end

    // direction and interrupt outputs
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            O_RTS <= 1'b0;
            O_IRQ <= 1'b0;
        end else if (I_CE) begin
            O_RTS <= dirctl_reg[rsu_pkg::CTL_RTS_BIT];
            O_IRQ <= dirctl_reg[rsu_pkg::CTL_IRQ_EN_BIT] && rx_out.valid;
        end
    end

    assign tx_load = (tx_state_reg == TX_IDLE) && thr_full_reg && link_run && tick16;

    // transmitter
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            tx_state_reg <= TX_IDLE;
            tx_phase_reg <= 4'h0;
            tx_bit_reg <= 3'h0;
            tx_shift_reg <= 8'h00;
            tx_stop2_reg <= 1'b0;
            O_TXD <= 1'b1;
        end else if (I_CE && tick16) begin
            case (tx_state_reg)
                TX_IDLE: begin
                    O_TXD <= 1'b1;
                    if (tx_load) begin
                        tx_shift_reg <= thr_reg;
                        tx_stop2_reg <= format_reg[rsu_pkg::FMT_STOP_BIT];
                        tx_phase_reg <= 4'h0;
                        O_TXD <= 1'b0;
                        tx_state_reg <= TX_START;
                    end
                end
                TX_START: begin
                    tx_phase_reg <= tx_phase_reg + 4'h1;
                    if (tx_phase_reg == 4'hF) begin
                        O_TXD <= tx_shift_reg[0];
                        tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                        tx_bit_reg <= 3'h0;
                        tx_state_reg <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    tx_phase_reg <= tx_phase_reg + 4'h1;
                    if (tx_phase_reg == 4'hF) begin
                        if ({1'b0, tx_bit_reg} == char_len - 4'h1) begin
                            O_TXD <= 1'b1;
                            tx_state_reg <= TX_STOP;
                        end else begin
                            O_TXD <= tx_shift_reg[0];
                            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                            tx_bit_reg <= tx_bit_reg + 3'h1;
                        end
                    end
                end
                TX_STOP: begin
                    tx_phase_reg <= tx_phase_reg + 4'h1;
                    if (tx_phase_reg == 4'hF) begin
                        if (tx_stop2_reg) begin
                            tx_stop2_reg <= 1'b0;
                        end else begin
                            tx_state_reg <= TX_IDLE;
                        end
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    // receiver: samples mid-bit on the 16x tick
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            rx_state_reg <= RX_IDLE;
            rx_phase_reg <= 4'h0;
            rx_bit_reg <= 3'h0;
            rx_shift_reg <= 8'h00;
            rx_char_reg <= 8'h00;
            rx_push_reg <= 1'b0;
        end else if (I_CE) begin
            rx_push_reg <= 1'b0;
            if (tick16) begin
                case (rx_state_reg)
                    RX_IDLE: begin
                        if (!I_RXD && link_run) begin
                            rx_phase_reg <= 4'h0;
                            rx_state_reg <= RX_START;
                        end
                    end
                    RX_START: begin
                        rx_phase_reg <= rx_phase_reg + 4'h1;
                        if (rx_phase_reg == 4'h7) begin
                            if (I_RXD) begin
                                rx_state_reg <= RX_IDLE;
                            end else begin
                                rx_phase_reg <= 4'h0;
                                rx_bit_reg <= 3'h0;
                                rx_shift_reg <= 8'h00;
                                rx_state_reg <= RX_DATA;
                            end
                        end
                    end
                    RX_DATA: begin
                        rx_phase_reg <= rx_phase_reg + 4'h1;
                        if (rx_phase_reg == 4'hF) begin
                            rx_shift_reg <= {I_RXD, rx_shift_reg[7:1]};
                            if ({1'b0, rx_bit_reg} == char_len - 4'h1) begin
                                rx_state_reg <= RX_STOP;
                            end else begin
                                rx_bit_reg <= rx_bit_reg + 3'h1;
                            end
                        end
                    end
                    RX_STOP: begin
                        rx_phase_reg <= rx_phase_reg + 4'h1;
                        if (rx_phase_reg == 4'hF) begin
                            rx_char_reg <= rx_shift_reg >> (4'h8 - char_len);
                            rx_push_reg <= I_RXD;
                            rx_state_reg <= RX_IDLE;
                        end
                    end
                    default: rx_state_reg <= RX_IDLE;
                endcase
            end
        end
    end

    property p_rts_follows;
        @(posedge I_CLOCK) disable iff (I_RST)
        I_CE |=> (O_RTS == $past(dirctl_reg[rsu_pkg::CTL_RTS_BIT]));
    endproperty
    a_rts_follows: assert property (p_rts_follows) else $error("rts not following control bit");

    property p_irq_gate;
        @(posedge I_CLOCK) disable iff (I_RST)
        !dirctl_reg[rsu_pkg::CTL_IRQ_EN_BIT] && I_CE |=> !O_IRQ;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

    property p_thr_set;
        @(posedge I_CLOCK) disable iff (I_RST)
        host_data_wr && I_CE |=> thr_full_reg;
    endproperty
    a_thr_set: assert property (p_thr_set) else $error("holding flag not set by write");

    property p_silent_div;
        @(posedge I_CLOCK) disable iff (I_RST)
        div_sel && tx_state_reg == TX_IDLE |=> tx_state_reg == TX_IDLE;
    endproperty
    a_silent_div: assert property (p_silent_div) else $error("transmit while divisor selected");

    property p_id_read;
        @(posedge I_CLOCK) disable iff (I_RST)
        I_CE && I_RD && I_ADDR == rsu_pkg::OFS_IRQ_ID |=>
            (O_RDATA == rsu_pkg::IRQ_ID_RX || O_RDATA == rsu_pkg::IRQ_ID_NONE);
    endproperty
    a_id_read: assert property (p_id_read) else $error("bad interrupt id value");

    property p_div_lo;
        @(posedge I_CLOCK) disable iff (I_RST)
        I_CE && I_WR && div_sel && I_ADDR == rsu_pkg::OFS_DATA |=> divisor_reg[7:0] == $past(I_WDATA);
    endproperty
    a_div_lo: assert property (p_div_lo) else $error("divisor low byte not loaded");

    property p_idle_line;
        @(posedge I_CLOCK) disable iff (I_RST)
        tx_state_reg == TX_IDLE && !tx_load |=> O_TXD;
    endproperty
    a_idle_line: assert property (p_idle_line) else $error("line not marking when idle");

    property p_stop_high;
        @(posedge I_CLOCK) disable iff (I_RST)
        tx_state_reg == TX_STOP |-> O_TXD;
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("stop bit low");
endmodule : rsu_uart
`default_nettype wire

// ==== design/rsu_pkg.sv ====
// package: register map, field positions, reset values and timing constants
package rsu_pkg;
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_DIV_HI = 3'h1;
    localparam logic [2:0] OFS_IRQ_ID = 3'h2;
    localparam logic [2:0] OFS_FORMAT = 3'h3;
    localparam logic [2:0] OFS_DIRCTL = 3'h4;
    localparam logic [2:0] OFS_FLAGS = 3'h5;
    localparam int FMT_LEN_LSB = 0;
    localparam int FMT_STOP_BIT = 2;
    localparam int FMT_DIV_SEL_BIT = 7;
    localparam int CTL_RTS_BIT = 1;
    localparam int CTL_USER_BIT = 2;
    localparam int CTL_IRQ_EN_BIT = 3;
    localparam int FLG_READY_BIT = 0;
    localparam int FLG_THR_EMPTY_BIT = 5;
    localparam logic [7:0] IRQ_ID_NONE = 8'h01;
    localparam logic [7:0] IRQ_ID_RX = 8'h04;
    localparam logic [7:0] FORMAT_RESET = 8'h00;
    localparam logic [7:0] DIRCTL_RESET = 8'h00;
    localparam logic [15:0] DIVISOR_RESET = 16'h000C;
    localparam int OVERSAMPLE = 16;
    localparam int LEN_BASE = 5;
    localparam int FIFO_DEPTH = 8;
    localparam int REF_CLOCK_HZ = 1843200;
    localparam int SYS_CLOCK_HZ = 25000000;
    // reference tick accumulator step, scaled by 2^16
    localparam logic [16:0] REF_STEP = 17'((64'(REF_CLOCK_HZ) * 65536) / SYS_CLOCK_HZ);
    localparam int MIN_BAUD = 50;
    localparam int MAX_BAUD = 9600;
endpackage : rsu_pkg

// ==== design/rsu_stream_if.sv ====
// interface: byte stream with valid/ready between the port and its fifo
`timescale 1ns/1ns
`default_nettype none
interface rsu_stream_if #(parameter int WIDTH = 8);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : rsu_stream_if
`default_nettype wire

// ==== design/rsu_fifo.sv ====
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module rsu_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    rsu_stream_if.snk wr,
    rsu_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;
    assign wr.ready = (cnt_reg != (AW+1)'(DEPTH));
    assign rd.valid = (cnt_reg != '0);
    assign rd.data = mem[rp_reg];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;
    always_ff @(posedge i_clk) begin
        if (i_ce && push) begin
            mem[wp_reg] <= wr.data;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else if (i_ce) begin
            if (push) begin
                wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
    property p_no_overflow;
        @(posedge i_clk) disable iff (i_rst)
        (cnt_reg <= (AW+1)'(DEPTH)) && ((cnt_reg == (AW+1)'(DEPTH)) == !wr.ready);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("fifo ready while full");
endmodule : rsu_fifo
`default_nettype wire

// ==== design/rsu_baud.sv ====
// baud tick generator: 16x oversample ticks from reference over divisor
`timescale 1ns/1ns
`default_nettype none
module rsu_baud (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [15:0] i_divisor,
    output logic o_tick16
);
    logic [16:0] acc_reg;
    logic [16:0] acc_sum;
    logic [15:0] div_cnt_reg;
    logic ref_tick;
    assign acc_sum = {1'b0, acc_reg[15:0]} + rsu_pkg::REF_STEP;
    // fractional accumulator recreates the reference clock rate
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            acc_reg <= '0;
        end else if (i_ce) begin
            acc_reg <= acc_sum;
        end
    end
    assign ref_tick = acc_reg[16];
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            div_cnt_reg <= 16'h0001;
            o_tick16 <= 1'b0;
        end else if (i_ce) begin
            o_tick16 <= 1'b0;
            if (ref_tick) begin
                if (div_cnt_reg <= 16'h0001) begin
                    div_cnt_reg <= (i_divisor == 16'h0000) ? 16'h0001 : i_divisor;
                    o_tick16 <= 1'b1;
                end else begin
                    div_cnt_reg <= div_cnt_reg - 16'h0001;
                end
            end
        end
    end
endmodule : rsu_baud
`default_nettype wire

// ==== sim/rsu_node.sv ====
// remote node and differential transceiver model on the far side of the port
`timescale 1ns/1ns
`default_nettype none
module rsu_node (
    // from the port
    input wire logic i_txd,
    input wire logic i_rts,
    // towards the port
    output logic o_line
);
    real bit_ns = 8680.6;
    int nbits = 8;
    int frames = 0;
    int raw_falls = 0;
    int gap = 0;
    int i;
    realtime last_start = 0;
    logic [7:0] got = 8'h00;
    logic pair;
    initial o_line = 1'b1;
    // driver tristated while direction is receive, bias keeps idle high
    assign pair = i_rts ? i_txd : 1'b1;
    // raw edges on the port output, to show direction never reaches it
    always @(negedge i_txd) raw_falls++;
    always @(negedge pair) begin
        gap = $rtoi(($realtime - last_start) / bit_ns + 0.5);
        last_start = $realtime;
        got = 8'h00;
        #(bit_ns * 1.5);
        for (i = 0; i < nbits; i++) begin
            got[i] = pair;
            #(bit_ns);
        end
        frames++;
    end
    // one 8N1 frame, lsb first
    task automatic send(input logic [7:0] b);
        o_line = 1'b0;
        #(bit_ns);
        for (int k = 0; k < 8; k++) begin
            o_line = b[k];
            #(bit_ns);
        end
        o_line = 1'b1;
        #(bit_ns);
    endtask : send
endmodule : rsu_node
`default_nettype wire

// ==== sim/rs485_uart_direction_ctrl_bench.sv ====
// self-checking bench for the serial port with transceiver direction control
`timescale 1ns/1ns
`default_nettype none
module rs485_uart_direction_ctrl_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic cts = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [7:0] q;
    logic irq;
    logic txd;
    logic rts;
    logic rxd;
    int error_cnt = 0;
    int tests_run = 0;
    int base;
    always #20 clk = ~clk;
    rsu_uart rsu_uart_inst (
        .I_CLOCK(clk),
        .I_RST(rst),
        .I_CE(1'b1),
        .I_ADDR(addr),
        .I_RD(rd),
        .I_WR(wr),
        .I_WDATA(wdata),
        .O_RDATA(rdata),
        .O_IRQ(irq),
        .I_RXD(rxd),
        .I_CTS(cts),
        .O_TXD(txd),
        .O_RTS(rts)
    );
    rsu_node rsu_node_inst (
        .i_txd(txd),
        .i_rts(rts),
        .o_line(rxd)
    );
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wreg
    task automatic rreg(input logic [2:0] a);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        q = rdata;
    endtask : rreg
    task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] exp);
        rreg(a);
        chk(what, q, exp);
    endtask : rchk
    task automatic wait_flag(input int b);
        for (int k = 0; k < 3000; k++) begin
            rreg(3'h5);
            if (q[b] === 1'b1) return;
        end
        error_cnt++;
        end_of_test();
    endtask : wait_flag
    task automatic wait_frames(input int want);
        for (int k = 0; k < 40000; k++) begin
            @(negedge clk);
            if (rsu_node_inst.frames >= want) return;
        end
        error_cnt++;
        end_of_test();
    endtask : wait_frames
    task automatic set_div(input logic [7:0] d, input logic [7:0] fmt);
        wreg(3'h3, 8'h80);
        wreg(3'h0, d);
        wreg(3'h1, 8'h00);
        rchk("div low", 3'h0, d);
        rchk("div high", 3'h1, 8'h00);
        wreg(3'h3, fmt);
        rsu_node_inst.bit_ns = 16.0e9 * d / 1843200.0;
    endtask : set_div
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        chk("txd idle", {7'h00, txd}, 8'h01);
        rchk("format", 3'h3, 8'h00);
        rchk("control", 3'h4, 8'h00);
        rchk("flags", 3'h5, 8'h20);
        rchk("irq id", 3'h2, 8'h01);
        rchk("offset 1", 3'h1, 8'h00);
        rchk("unmapped", 3'h6, 8'h00);
        $display("test reset done");
        base = rsu_node_inst.raw_falls;
        wreg(3'h4, 8'h06);
        @(negedge clk);
        chk("rts on", {7'h00, rts}, 8'h01);
        rchk("control", 3'h4, 8'h06);
        wreg(3'h4, 8'h04);
        @(negedge clk);
        chk("rts off", {7'h00, rts}, 8'h00);
        chk("txd quiet", 8'(rsu_node_inst.raw_falls - base), 8'h00);
        $display("test direction done");
        // divisor select holds the line silent and steers offset 0
        wreg(3'h4, 8'h02);
        wreg(3'h3, 8'h83);
        rchk("div reset", 3'h0, 8'h0C);
        wreg(3'h0, 8'h01);
        rsu_node_inst.send(8'hA5);
        chk("halted", 8'(rsu_node_inst.raw_falls - base), 8'h00);
        rchk("rx halted", 3'h5, 8'h20);
        rchk("div low", 3'h0, 8'h01);
        $display("test divisor select done");
        for (int c = 0; c < 4; c++) begin
            cts = 1'(c % 2);
            set_div(8'(1 + c / 3), 8'(c + 4 * (c % 2)));
            rsu_node_inst.nbits = 5 + c;
            base = rsu_node_inst.frames;
            wreg(3'h0, 8'hC3);
            wait_flag(5);
            wreg(3'h0, 8'h5A + 8'(c));
            rchk("flags busy", 3'h5, 8'h00);
            wait_frames(base + 2);
            chk("tx data", rsu_node_inst.got, (8'h5A + 8'(c)) & 8'((1 << (5 + c)) - 1));
            chk("frame bits", 8'(rsu_node_inst.gap), 8'(7 + c + c % 2));
        end
        // host drops direction without touching the other bits
        rreg(3'h4);
        wreg(3'h4, q & 8'hFD);
        rchk("control", 3'h4, 8'h00);
        chk("rts off", {7'h00, rts}, 8'h00);
        $display("test transmit done");
        set_div(8'h01, 8'h03);
        rsu_node_inst.nbits = 8;
        wreg(3'h4, 8'h08);
        rsu_node_inst.send(8'h3C);
        wait_flag(0);
        chk("irq on", {7'h00, irq}, 8'h01);
        rchk("irq id", 3'h2, 8'h04);
        rchk("rx data", 3'h0, 8'h3C);
        rchk("flags", 3'h5, 8'h20);
        rchk("irq id", 3'h2, 8'h01);
        chk("irq off", {7'h00, irq}, 8'h00);
        wreg(3'h4, 8'h00);
        rsu_node_inst.send(8'hC5);
        wait_flag(0);
        chk("irq gated", {7'h00, irq}, 8'h00);
        rchk("rx data", 3'h0, 8'hC5);
        $display("test receive done");
        rsu_node_inst.send(8'h77);
        rsu_node_inst.send(8'h78);
        rreg(3'h0);
        rreg(3'h0);
        rchk("flushed", 3'h5, 8'h20);
        // nine characters into eight places: the last is dropped
        for (int i = 0; i < 9; i++) begin
            rsu_node_inst.send(8'h10 + 8'(i));
        end
        rchk("flags", 3'h5, 8'h21);
        for (int i = 0; i < 8; i++) begin
            rchk("fifo data", 3'h0, 8'h10 + 8'(i));
        end
        rchk("flags", 3'h5, 8'h20);
        $display("test fifo done");
        end_of_test();
    end
endmodule : rs485_uart_direction_ctrl_bench
`default_nettype wire
